/* design/twal_fault_q.sv */
// Consecutive-fault qualifier for one comparison.
// Assumes i_sample pulses once per new temperature result.
`timescale 1ns/100ps
module twal_fault_q
    import twal_pkg::*;
(
    input wire logic i_clk_sys, // System clock
    input wire logic i_rst_n, // Async reset, active low
    input wire logic i_ce, // Clock enable
    input wire logic i_clr, // Clear count and output
    input wire logic i_sample, // New result strobe
    input wire logic i_raw, // Raw condition of this result
    input wire logic i_fq_en, // Fault queue enabled
    output logic o_qual // Qualified condition
);

    typedef struct packed {
        logic [2:0] cnt;
        logic qual;
    } twal_fq_state_t;

    twal_fq_state_t st_ff;
    twal_fq_state_t nxt_st;

    // ------------------------------------------------------------
    // Count consecutive hits; a miss restarts the run
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (i_clr) begin
            nxt_st.cnt = 3'h0;
            nxt_st.qual = 1'b0;
        end else if (i_sample) begin
            if (!i_raw) begin
                nxt_st.cnt = 3'h0;
                nxt_st.qual = 1'b0;
            end else if (!i_fq_en) begin
                nxt_st.cnt = TWAL_FAULT_ONE;
                nxt_st.qual = 1'b1;
            end else begin
                // Saturate so a long excursion never wraps around
                if (st_ff.cnt < TWAL_FAULT_DEPTH) begin
                    nxt_st.cnt = st_ff.cnt + TWAL_FAULT_ONE;
                end
                nxt_st.qual = (st_ff.cnt + TWAL_FAULT_ONE) >= TWAL_FAULT_DEPTH;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_ff <= '0;
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    assign o_qual = st_ff.qual;

endmodule // twal_fault_q

/* design/twal_pkg.sv */
// Package for the thermal window alert logic: widths, field layouts,
// reset values and the carrier structs shared by the design files.
// Assumes temperatures arrive as 13-bit two's complement, 0.0625 C per LSB.
package twal_pkg;

    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int TWAL_TEMP_W = 13;
    localparam logic [2:0] TWAL_FAULT_DEPTH = 3'h4;
    localparam logic [2:0] TWAL_FAULT_ONE = 3'h1;

    // ------------------------------------------------------------
    // Reset values of limits (same scale as the temperature)
    // ------------------------------------------------------------
    localparam logic [12:0] TWAL_RST_HYST = 13'h0020;
    localparam logic [12:0] TWAL_RST_LOW = 13'h00A0;
    localparam logic [12:0] TWAL_RST_HIGH = 13'h0400;
    localparam logic [12:0] TWAL_RST_CRIT = 13'h0500;

    // ------------------------------------------------------------
    // Configuration bit positions and reset value
    // ------------------------------------------------------------
    localparam int TWAL_CFG_SHDN = 0;
    localparam int TWAL_CFG_MODE = 1;
    localparam int TWAL_CFG_CPOL = 2;
    localparam int TWAL_CFG_IPOL = 3;
    localparam int TWAL_CFG_FQ = 4;
    localparam logic [4:0] TWAL_RST_CFG = 5'h00;

    // Interrupt mode values
    localparam logic TWAL_MODE_COMP = 1'b0;
    localparam logic TWAL_MODE_EVENT = 1'b1;

    // Limits carried together
    typedef struct packed {
        logic signed [12:0] hyst;
        logic signed [12:0] low;
        logic signed [12:0] high;
        logic signed [12:0] crit;
    } twal_limits_t;

    // Limit-exceeded flags
    typedef struct packed {
        logic crit;
        logic high;
        logic low;
    } twal_flags_t;

endpackage : twal_pkg

/* design/twal_top.sv */
// Thermal window alert logic: window interrupt, critical alarm, flags.
// Assumes temperature results and limits come from same-clock logic;
// the host read strobe and limit writes are one-cycle pulses.
//
// Overview of operation
// - The interrupt goes active whenever temperature leaves the window on either side.
// - Rising above the upper limit activates the interrupt and sets the high flag.
// - Falling below the lower limit activates the interrupt and sets the low flag.
// - In event mode, new limits that bring temperature inside give one more interrupt.
// - In comparator mode, new limits that bring temperature inside just drop it.
// - A critical event activates the separate critical alarm output.
// - Configuration bit one picks comparator (0) or event (1) mode, comparator at reset.
// - In event mode a host read deasserts the interrupt unless a new event sets it in that same cycle.
// - With the fault queue on, four consecutive out-of-limit results are needed.
// - Shutdown returns both alert outputs to inactive.
`timescale 1ns/100ps
module twal_top
    import twal_pkg::*;
(
    input wire logic i_clk_sys, // System clock, 25 MHz
    input wire logic i_rst_n, // Async reset, active low
    input wire logic i_ce, // Clock enable, freezes all state
    input wire logic i_sample, // New temperature result strobe
    input wire logic signed [12:0] i_temp, // Measured temperature
    input wire logic i_lim_we, // Limit write strobe
    input wire twal_limits_t i_lim_wdata, // Limits to write
    input wire logic i_cfg_we, // Configuration write strobe
    input wire logic [4:0] i_cfg_wdata, // Configuration to write
    input wire logic i_host_rd, // Any host read, one-cycle pulse
    output twal_limits_t o_limits, // Current limits
    output logic [4:0] o_cfg, // Current configuration
    output twal_flags_t o_flags, // Limit-exceeded flags
    output logic o_int_oe_n, // Interrupt pin enable, low drives
    output logic o_int_out, // Interrupt pin driven level
    output logic o_crit_oe_n, // Critical alarm enable, low drives
    output logic o_crit_out // Critical alarm driven level
);

    typedef struct packed {
        twal_limits_t lim;
        logic [4:0] cfg;
        logic above; // High side state with hysteresis
        logic below; // Low side state with hysteresis
        logic crit; // Critical state with hysteresis
        logic int_act; // Interrupt active
        logic int_out;
        logic int_oe_n;
        logic crit_out;
        logic crit_oe_n;
        logic recheck; // Limits changed, reevaluate next result
        logic fresh; // A result under the current limits just landed
    } twal_state_t;

    twal_state_t st_ff;
    twal_state_t nxt_st;

    logic shdn;
    logic ev_mode;
    logic fq_en;
    logic signed [13:0] t_ext;
    logic raw_hi;
    logic raw_lo;
    logic raw_cr;
    logic q_hi;
    logic q_lo;
    logic q_cr;
    logic eval;
    logic in_win_q;
    logic was_out;

    assign shdn = st_ff.cfg[TWAL_CFG_SHDN];
    assign ev_mode = (st_ff.cfg[TWAL_CFG_MODE] == TWAL_MODE_EVENT);
    assign fq_en = st_ff.cfg[TWAL_CFG_FQ];
    assign t_ext = 14'(i_temp);

    // ------------------------------------------------------------
    // Hysteresis comparisons; widened to avoid overflow at the ends
    // ------------------------------------------------------------
    always_comb begin
        // Once tripped, a side releases only past the limit by hysteresis
        raw_hi = st_ff.above ? (t_ext > 14'(st_ff.lim.high) - 14'(st_ff.lim.hyst))
                             : (t_ext > 14'(st_ff.lim.high));
        raw_lo = st_ff.below ? (t_ext < 14'(st_ff.lim.low) + 14'(st_ff.lim.hyst))
                             : (t_ext < 14'(st_ff.lim.low));
        raw_cr = st_ff.crit ? (t_ext > 14'(st_ff.lim.crit) - 14'(st_ff.lim.hyst))
                            : (t_ext > 14'(st_ff.lim.crit));
    end

    // Conversions stop in shutdown, so results are ignored there
    assign eval = i_sample && !shdn;

    // ------------------------------------------------------------
    // One fault qualifier per comparison
    // ------------------------------------------------------------
    twal_fault_q u_fq_hi (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_clr(shdn),
        .i_sample(eval),
        .i_raw(raw_hi),
        .i_fq_en(fq_en),
        .o_qual(q_hi)
    );

    twal_fault_q u_fq_lo (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_clr(shdn),
        .i_sample(eval),
        .i_raw(raw_lo),
        .i_fq_en(fq_en),
        .o_qual(q_lo)
    );

    twal_fault_q u_fq_cr (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_clr(shdn),
        .i_sample(eval),
        .i_raw(raw_cr),
        .i_fq_en(fq_en),
        .o_qual(q_cr)
    );

    assign was_out = st_ff.above || st_ff.below;
    assign in_win_q = !q_hi && !q_lo;

    // ------------------------------------------------------------
    // Alert state; qualified states update the cycle after a result
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (i_lim_we) begin
            nxt_st.lim = i_lim_wdata;
            nxt_st.recheck = 1'b1;
        end
        if (i_cfg_we) begin
            nxt_st.cfg = i_cfg_wdata;
        end
        nxt_st.above = q_hi;
        nxt_st.below = q_lo;
        nxt_st.crit = q_cr;
        if (ev_mode) begin
            // Event mode: edges set it, host read clears it; set wins
            if (i_host_rd) begin
                nxt_st.int_act = 1'b0;
            end
            if ((q_hi && !st_ff.above) || (q_lo && !st_ff.below)) begin
                nxt_st.int_act = 1'b1;
            end
            // First result after new limits: was outside, now inside
            if (st_ff.recheck && st_ff.fresh && was_out && in_win_q) begin
                nxt_st.int_act = 1'b1;
            end
        end else begin
            // Comparator mode: follows the out-of-window state only
            nxt_st.int_act = q_hi || q_lo;
        end
        // Qualifiers only move on a result, so recheck waits for one
        nxt_st.fresh = eval && !i_lim_we;
        if (st_ff.recheck && st_ff.fresh && !i_lim_we) begin
            nxt_st.recheck = 1'b0;
        end
        if (shdn) begin
            nxt_st.int_act = 1'b0;
            nxt_st.above = 1'b0;
            nxt_st.below = 1'b0;
            nxt_st.crit = 1'b0;
            nxt_st.recheck = 1'b0;
        end
        // Polarity bits choose the asserted level of each pin
        nxt_st.int_out = nxt_st.int_act ~^ nxt_st.cfg[TWAL_CFG_IPOL];
        nxt_st.int_oe_n = nxt_st.int_out;
        nxt_st.crit_out = nxt_st.crit ~^ nxt_st.cfg[TWAL_CFG_CPOL];
        nxt_st.crit_oe_n = nxt_st.crit_out;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_ff.lim <= '{hyst: TWAL_RST_HYST, low: TWAL_RST_LOW,
                           high: TWAL_RST_HIGH, crit: TWAL_RST_CRIT};
            st_ff.cfg <= TWAL_RST_CFG;
            st_ff.above <= 1'b0;
            st_ff.below <= 1'b0;
            st_ff.crit <= 1'b0;
            st_ff.int_act <= 1'b0;
            st_ff.int_out <= 1'b1;
            st_ff.int_oe_n <= 1'b1;
            st_ff.crit_out <= 1'b1;
            st_ff.crit_oe_n <= 1'b1;
            st_ff.recheck <= 1'b0;
            st_ff.fresh <= 1'b0;
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    assign o_limits = st_ff.lim;
    assign o_cfg = st_ff.cfg;
    assign o_flags = '{crit: st_ff.crit, high: st_ff.above, low: st_ff.below};
    assign o_int_out = st_ff.int_out;
    assign o_int_oe_n = st_ff.int_oe_n;
    assign o_crit_out = st_ff.crit_out;
    assign o_crit_oe_n = st_ff.crit_oe_n;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    shdn_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_ce && shdn) |=> (!st_ff.int_act && !st_ff.crit))
        else $error("alert active after shutdown");

    comp_follow_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_ce && !ev_mode && !shdn) |=> (st_ff.int_act == $past(q_hi || q_lo)))
        else $error("comparator interrupt not following window");

    read_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_ce && ev_mode && i_host_rd && !shdn && !st_ff.recheck
         && !(q_hi && !st_ff.above) && !(q_lo && !st_ff.below)) |=> !st_ff.int_act)
        else $error("read did not clear event interrupt");

    high_edge_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_ce && !shdn && q_hi && !st_ff.above) |=> (st_ff.int_act && o_flags.high))
        else $error("high crossing missed");

    low_edge_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_ce && !shdn && q_lo && !st_ff.below) |=> (st_ff.int_act && o_flags.low))
        else $error("low crossing missed");

    crit_pin_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_crit_out == (st_ff.crit ~^ st_ff.cfg[TWAL_CFG_CPOL])))
        else $error("critical pin level wrong");

    crit_follow_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_ce && !shdn) |=> (st_ff.crit == $past(q_cr)))
        else $error("critical alarm not comparator");

    int_pin_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_int_out == (st_ff.int_act ~^ st_ff.cfg[TWAL_CFG_IPOL])))
        else $error("interrupt pin level wrong");

    back_in_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_ce && ev_mode && !shdn && st_ff.recheck && st_ff.fresh && was_out && in_win_q)
        |=> st_ff.int_act)
        else $error("return to window not signalled");

    mode_reset_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        $rose(i_rst_n) |-> (st_ff.cfg[TWAL_CFG_MODE] == TWAL_MODE_COMP))
        else $error("mode not comparator after reset");

endmodule // twal_top

/* testbench/test_twal_top.sv */
// Bench for the thermal window alert logic: drives results, limits and
// configuration, queues expected alert states and compares them.
// Assumes one 25 MHz clock and the host model beside the design.
`timescale 1ns/100ps
module test_twal_top
    import twal_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, smp_v = 1'b0;
    logic cfg_we = 1'b0, tb_we = 1'b0, tb_rd = 1'b0, h_en = 1'b0, h_rd, h_we;
    logic ipol = 1'b0, cpol = 1'b0, int_out, int_oe_n, crit_out, crit_oe_n;
    logic signed [12:0] temp = '0, ti, th, tl, tc;
    logic [4:0] cfg_d = '0, cfg;
    logic [7:0] h_wait = 8'h02;
    twal_limits_t tb_lim = '0, h_lim, lim;
    twal_flags_t flags;
    logic [6:0] q[$];
    int n_mismatch = 0, total_checks = 0, seed = 32'h29b4b60f, i;
    event look;
    // Pin level with its pull-up, active when equal to the polarity bit
    wire int_act = ((int_oe_n ? 1'b1 : int_out) == ipol);

    twal_top i_twal_top (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(ce), .i_sample(smp_v),
        .i_temp(temp), .i_lim_we(tb_we | h_we), .i_lim_wdata(h_we ? h_lim : tb_lim),
        .i_cfg_we(cfg_we), .i_cfg_wdata(cfg_d), .i_host_rd(tb_rd | h_rd),
        .o_limits(lim), .o_cfg(cfg), .o_flags(flags), .o_int_oe_n(int_oe_n),
        .o_int_out(int_out), .o_crit_oe_n(crit_oe_n), .o_crit_out(crit_out));
    twal_host_model i_twal_host_model (.i_clk_sys(clk), .i_en(h_en), .i_int_act(int_act),
        .i_wait(h_wait), .i_flags(flags), .i_limits(lim), .o_rd(h_rd), .o_lim_we(h_we),
        .o_lim(h_lim));

    // ------------------------------------------------------------
    // Clock, checking and closing
    // ------------------------------------------------------------
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        total_checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%0h want=%0h", $time, seen, want);
        end
    endtask
    // Open drain: the pin level and its enable both follow the polarity
    task automatic expect_st(input logic [2:0] f, input logic ia, input logic ca);
        logic io;
        logic co;
        io = ia ? ipol : ~ipol;
        co = ca ? cpol : ~cpol;
        q.push_back({f, io, io, co, co});
        -> look;
    endtask
    // Watcher takes the oldest note once the driver says outputs settled
    always begin
        @(look);
        check({flags, int_out, int_oe_n, crit_out, crit_oe_n}, q.pop_front());
    end
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Cut a hang well past the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end

    // One result, then time for the two-edge answer to land
    task automatic smp(input logic signed [12:0] t);
        @(posedge clk);
        #1 smp_v = 1'b1;
        temp = t;
        @(posedge clk);
        #1 smp_v = 1'b0;
        temp = ~t;
        repeat (4) @(posedge clk);
        #1;
    endtask
    // Kind 0 writes config, 1 writes limits, 2 is a host read
    task automatic poke(input int k, input logic [51:0] d);
        @(posedge clk);
        #1 cfg_we = (k == 0);
        tb_we = (k == 1);
        tb_rd = (k == 2);
        cfg_d = d[4:0];
        tb_lim = d;
        @(posedge clk);
        #1 {cfg_we, tb_we, tb_rd} = 3'h0;
        cfg_d = ~cfg_d;
        tb_lim = ~tb_lim;
        if (k == 0) {ipol, cpol} = {d[TWAL_CFG_IPOL], d[TWAL_CFG_CPOL]};
        repeat (3) @(posedge clk);
        #1;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        check({lim, cfg}, {TWAL_RST_HYST, TWAL_RST_LOW, TWAL_RST_HIGH, TWAL_RST_CRIT,
            TWAL_RST_CFG});
        expect_st(3'h0, 1'b0, 1'b0);
        $display("test reset done");
        // Random temperatures kept clear of the hysteresis bands
        for (i = 0; i < 3; i++) begin
            ti = 13'h0D0 + 13'($random(seed) & 32'h1FF);
            th = 13'h410 + 13'($random(seed) & 32'h7F);
            tl = 13'($random(seed) & 32'h7F);
            tc = 13'h510 + 13'($random(seed) & 32'hFF);
            smp(ti);
            expect_st(3'h0, 1'b0, 1'b0);
            smp(th);
            expect_st(3'h2, 1'b1, 1'b0);
            smp(ti);
            expect_st(3'h0, 1'b0, 1'b0);
            smp(tl);
            expect_st(3'h1, 1'b1, 1'b0);
            smp(tc);
            expect_st(3'h6, 1'b1, 1'b1);
            smp(ti);
            expect_st(3'h0, 1'b0, 1'b0);
        end
        ce = 1'b0;
        smp(th);
        expect_st(3'h0, 1'b0, 1'b0);
        ce = 1'b1;
        $display("test comparator done");
        // Event mode, slow host moves the window up
        poke(0, 52'h02);
        h_wait = 8'd20;
        h_en = 1'b1;
        smp(th);
        expect_st(3'h2, 1'b1, 1'b0);
        repeat (60) @(posedge clk);
        #1 expect_st(3'h2, 1'b0, 1'b0);
        check(lim.high, TWAL_RST_HIGH + 13'h100);
        h_en = 1'b0;
        smp(th);
        expect_st(3'h0, 1'b1, 1'b0);
        poke(2, '0);
        expect_st(3'h0, 1'b0, 1'b0);
        $display("test event done");
        // Comparator mode, prompt host; reads leave the interrupt alone
        poke(0, 52'h00);
        poke(1, {TWAL_RST_HYST, TWAL_RST_LOW, TWAL_RST_HIGH, TWAL_RST_CRIT});
        h_wait = 8'd2;
        h_en = 1'b1;
        smp(th);
        repeat (30) @(posedge clk);
        #1 expect_st(3'h2, 1'b1, 1'b0);
        check(lim.low, TWAL_RST_LOW + 13'h100);
        h_en = 1'b0;
        smp(th);
        expect_st(3'h0, 1'b0, 1'b0);
        $display("test window move done");
        // Fault queue needs four results in a row
        poke(1, {TWAL_RST_HYST, TWAL_RST_LOW, TWAL_RST_HIGH, TWAL_RST_CRIT});
        poke(0, 52'h10);
        for (i = 0; i < 4; i++) begin
            smp(th);
            expect_st((i == 3) ? 3'h2 : 3'h0, i == 3, 1'b0);
        end
        $display("test fault queue done");
        // Active-high polarity, then shutdown drops all and refuses results
        poke(0, 52'h0C);
        smp(tc);
        expect_st(3'h6, 1'b1, 1'b1);
        poke(0, 52'h0D);
        expect_st(3'h0, 1'b0, 1'b0);
        smp(tc);
        expect_st(3'h0, 1'b0, 1'b0);
        $display("test shutdown done");
        tally_and_finish();
    end
endmodule // test_twal_top

/* testbench/twal_host_model.sv */
// Host model: serves the window interrupt, reads flags, moves limits.
// Assumes the bench resolves the open-drain pin and reports it active.
`timescale 1ns/100ps
module twal_host_model
    import twal_pkg::*;
(
    input wire logic i_clk_sys, // System clock
    input wire logic i_en, // Servicing enabled
    input wire logic i_int_act, // Interrupt pin active
    input wire logic [7:0] i_wait, // Service latency, cycles
    input wire twal_flags_t i_flags, // Flags read back
    input wire twal_limits_t i_limits, // Limits read back
    output logic o_rd, // Read strobe
    output logic o_lim_we, // Limit write strobe
    output twal_limits_t o_lim // Limits to write
);
    localparam logic [12:0] STEP = 13'h100; // Window granularity
    twal_flags_t f;
    twal_limits_t l;
    // ------------------------------------------------------------
    // Service loop
    // ------------------------------------------------------------
    // Waits for the pin to clear, so a standing comparator interrupt
    // is not served twice
    initial begin
        o_rd = 1'b0;
        o_lim_we = 1'b0;
        o_lim = '0;
        forever begin
            do @(posedge i_clk_sys); while (!(i_en && i_int_act));
            repeat (i_wait) @(posedge i_clk_sys);
            #1 o_rd = 1'b1;
            @(posedge i_clk_sys);
            f = i_flags;
            l = i_limits;
            #1 o_rd = 1'b0;
            if (f.high || f.low) begin
                l.high = f.high ? l.high + STEP : l.high - STEP;
                l.low = f.high ? l.low + STEP : l.low - STEP;
                o_lim = l;
                o_lim_we = 1'b1;
                @(posedge i_clk_sys);
                #1 o_lim_we = 1'b0;
                o_lim = ~l; // Released data is not held
            end
            do @(posedge i_clk_sys); while (i_int_act);
        end
    end
endmodule // twal_host_model
